// *** rtl/glue_pkg.sv ***
package glue_pkg;

  // address bit positions on the host bus
  localparam int ADDR_W     = 18;
  localparam int BIT_A2     = 2;
  localparam int BIT_A14    = 14;
  localparam int BIT_A15    = 15;
  localparam int BIT_A16    = 16;
  localparam int BIT_A17    = 17;
  // page size in bytes and the ram alias page base
  localparam int PAGE_BYTES = 16384;
  localparam logic [ADDR_W-1:0] RAM_ALIAS_BASE = 18'h14000;
  // number of wait stages in the rom acknowledge chain
  localparam int WAIT_STAGES = 3;

  // host bus cycle as seen by the decoder
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              address_strobe_n;
    logic              data_strobe_n;
    logic              read_not_write;
  } host_cycle_t;

  // active-low select group
  typedef struct packed {
    logic rom_select_n;
    logic sram_select_n;
    logic link_controller_select_n;
    logic uart_select_n;
    logic controller_vector_ack_n;
    logic autovector_request_n;
    logic write_enable_n;
    logic output_enable_n;
  } selects_t;

  // one three-state acknowledge: level and enable
  typedef struct packed {
    logic level;
    logic oe;
  } tri_ack_t;

endpackage : glue_pkg

// *** rtl/ack_wait_chain.sv ***
`timescale 1ns/10ps
module ack_wait_chain (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // rom select, active low, same clock domain
  input  wire logic              rom_select_n_i,
  // stage outputs, active when high
  output logic [glue_pkg::WAIT_STAGES-1:0] stage_o
);
  import glue_pkg::*;

  logic [WAIT_STAGES-1:0] stage_r;
  logic [WAIT_STAGES-1:0] stage_nxt;

  // each stage sets only if the select and all earlier stages hold
  genvar g;
  generate
    for (g = 0; g < WAIT_STAGES; g++) begin : g_stage
      if (g == 0) begin : g_first
        assign stage_nxt[g] = ~rom_select_n_i;
      end else begin : g_later
        assign stage_nxt[g] = ~rom_select_n_i & (&stage_r[g-1:0]);
      end
    end
  endgenerate

  // reset only to give a defined start; the chain clears itself when the select drops
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stage_r <= '0;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign stage_o = stage_r;

endmodule : ack_wait_chain

// *** rtl/host_address_decoder_ack_gen.sv ***
`timescale 1ns/10ps
// Overview of operation
// - address space split in 16K pages: rom four, controller, uart, ram one each
// - partial decode: ram alias page at 14000, controller and uart alias in page
// - ram select: strobe low, A15 low, A16 with both owners high or one owner low
// - write enable: data strobe low, write, plus ram select terms
// - output enable: data strobe low, read, plus ram select terms
// - vector fetch detected by A17 with address strobe low
// - vector fetch with A2 high asserts controller vector acknowledge
// - vector fetch with A2 low asserts autovector request
// - three clocked stages chain on rom select
// - normal rom ack on stages one, two; delayed on two, three
// - ram acknowledge follows ram select directly, open drain
// - each acknowledge released while its select is inactive
module host_address_decoder_ack_gen (
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  // host bus
  input  wire glue_pkg::host_cycle_t host_i,
  // link controller page owner pins, asynchronous
  input  wire logic                 page_owner_a_i,
  input  wire logic                 page_owner_b_i,
  // selects and strobes, active low
  output glue_pkg::selects_t        selects_o,
  // rom acknowledges, three-state, driven high until their stages set, then low
  output glue_pkg::tri_ack_t        rom_ack_normal_o,
  output glue_pkg::tri_ack_t        rom_ack_delayed_o,
  // ram acknowledge, open drain
  output glue_pkg::tri_ack_t        sram_transfer_ack_o
);
  import glue_pkg::*;

  // decode one bus state into selects; used for the registered outputs
  function automatic selects_t decode(input logic [ADDR_W-1:0] a, input logic as_n,
                                      input logic ds_n, input logic rnw,
                                      input logic own_a, input logic own_b);
    selects_t s;
    logic     as;
    logic     ram_hit;
    logic     vec;
    as  = ~as_n;
    vec = as & a[BIT_A17];
    // both owners high with A16, or exactly one owner low
    ram_hit = as & ~a[BIT_A15] &
              ((a[BIT_A16] & own_a & own_b) | (own_a ^ own_b));
    s.rom_select_n             = ~(as & ~a[BIT_A16]);
    s.sram_select_n            = ~ram_hit;
    s.link_controller_select_n = ~(as & a[BIT_A16] & a[BIT_A15] & ~a[BIT_A14]);
    s.uart_select_n            = ~(as & a[BIT_A16] & a[BIT_A15] & a[BIT_A14]);
    s.controller_vector_ack_n  = ~(vec & a[BIT_A2]);
    s.autovector_request_n     = ~(vec & ~a[BIT_A2]);
    s.write_enable_n           = ~(ram_hit & ~ds_n & ~rnw);
    s.output_enable_n          = ~(ram_hit & ~ds_n & rnw);
    return s;
  endfunction : decode

  // pins from outside pass three flops; change counts when stages two and three agree
  logic [2:0] own_a_sync_r;
  logic [2:0] own_b_sync_r;
  logic       own_a_r;
  logic       own_b_r;

  // owner inputs start high: no page owned after reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      own_a_sync_r <= 3'h7;
      own_b_sync_r <= 3'h7;
    end else begin
      own_a_sync_r <= {own_a_sync_r[1:0], page_owner_a_i};
      own_b_sync_r <= {own_b_sync_r[1:0], page_owner_b_i};
    end
  end

  // filtered owner levels
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      own_a_r <= 1'b1;
      own_b_r <= 1'b1;
    end else begin
      if (own_a_sync_r[1] == own_a_sync_r[2]) begin
        own_a_r <= own_a_sync_r[2];
      end
      if (own_b_sync_r[1] == own_b_sync_r[2]) begin
        own_b_r <= own_b_sync_r[2];
      end
    end
  end

  // host bus comes from logic on this clock, so it is used directly
  selects_t sel_nxt;
  selects_t sel_r;

  always_comb begin
    sel_nxt = decode(host_i.addr, host_i.address_strobe_n, host_i.data_strobe_n,
                     host_i.read_not_write, own_a_r, own_b_r);
  end

  // registered selects cost one cycle but keep every output on a flop
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sel_r <= '1;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // wait chain follows the decoded rom select ahead of its register
  logic [WAIT_STAGES-1:0] stage_w;

  ack_wait_chain u_chain (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .rom_select_n_i (sel_nxt.rom_select_n),
    .stage_o        (stage_w)
  );

  // acknowledges, registered; level low when asserted, enable tracks own select
  tri_ack_t ack_norm_r;
  tri_ack_t ack_dly_r;
  tri_ack_t ack_ram_r;
  logic     rom_on;

  assign rom_on = ~sel_nxt.rom_select_n;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_norm_r <= '{level: 1'b1, oe: 1'b0};
      ack_dly_r  <= '{level: 1'b1, oe: 1'b0};
    end else begin
      // stage_w still holds the stages set from the previous edge's rom select
      ack_norm_r.level <= ~(rom_on & stage_w[0] & stage_w[1]);
      ack_dly_r.level  <= ~(rom_on & stage_w[1] & stage_w[2]);
      ack_norm_r.oe    <= rom_on;
      ack_dly_r.oe     <= rom_on;
    end
  end

  // open drain: only ever drives low, and only while ram is selected
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_ram_r <= '{level: 1'b1, oe: 1'b0};
    end else begin
      ack_ram_r.level <= 1'b0;
      ack_ram_r.oe    <= ~sel_nxt.sram_select_n;
    end
  end

  assign selects_o           = sel_r;
  assign rom_ack_normal_o    = ack_norm_r;
  assign rom_ack_delayed_o   = ack_dly_r;
  assign sram_transfer_ack_o = ack_ram_r;

endmodule : host_address_decoder_ack_gen

// *** testbench/glue_properties.sv ***
`timescale 1ns/10ps
module glue_checker (
  // clock and reset
  input wire logic                  clk_sys_i,
  input wire logic                  rst_i,
  // watched ports
  input wire glue_pkg::host_cycle_t host_i,
  input wire glue_pkg::selects_t    selects_o,
  input wire glue_pkg::tri_ack_t    rom_ack_normal_o,
  input wire glue_pkg::tri_ack_t    rom_ack_delayed_o,
  input wire glue_pkg::tri_ack_t    sram_transfer_ack_o
);
  import glue_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire [17:0] a = host_i.addr;
  wire        s = !host_i.address_strobe_n;
  logic       live_r;
  // outputs are registered, so the first edge after reset has no history yet
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) live_r <= 1'b0;
    else live_r <= 1'b1;
  end
  sequence rom_run;
    $rose(rom_ack_normal_o.oe) ##1 rom_ack_normal_o.oe;
  endsequence
  chk_rom_select: assert property (
    live_r |-> selects_o.rom_select_n == !$past(s & ~a[16])) else $error("rom select");
  chk_uart_select: assert property (
    live_r |-> selects_o.uart_select_n == !$past(s & a[16] & a[15] & a[14])) else $error("uart");
  chk_vector_ack: assert property (
    live_r |-> selects_o.controller_vector_ack_n == !$past(s & a[17] & a[2])) else $error("interrupt_vector_ack");
  chk_autovector_req: assert property (
    live_r |-> selects_o.autovector_request_n == !$past(s & a[17] & ~a[2])) else $error("avec");
  chk_ram_terms: assert property (
    live_r && !selects_o.sram_select_n |-> $past(s & ~a[15])) else $error("ram select");
  chk_write_enable: assert property (
    live_r && !selects_o.write_enable_n |-> !selects_o.sram_select_n
      && $past(!host_i.data_strobe_n && !host_i.read_not_write)) else $error("write enable");
  chk_output_enable: assert property (
    live_r && !selects_o.output_enable_n |-> !selects_o.sram_select_n
      && $past(!host_i.data_strobe_n && host_i.read_not_write)) else $error("output enable");
  chk_ack_follows_select: assert property (
    rom_ack_normal_o.oe == !selects_o.rom_select_n && rom_ack_delayed_o.oe == rom_ack_normal_o.oe
      && sram_transfer_ack_o.oe == !selects_o.sram_select_n
      && !(sram_transfer_ack_o.oe && sram_transfer_ack_o.level)) else $error("ack enable");
  chk_normal_ack_time: assert property (
    rom_run |-> rom_ack_normal_o.level ##1 (!rom_ack_normal_o.oe || !rom_ack_normal_o.level))
    else $error("normal ack");
  chk_delayed_ack_time: assert property (
    rom_run ##1 rom_ack_delayed_o.oe |-> rom_ack_delayed_o.level
      ##1 (!rom_ack_delayed_o.oe || !rom_ack_delayed_o.level)) else $error("delayed ack");
endmodule : glue_checker
bind host_address_decoder_ack_gen glue_checker u_glue_checker (.clk_sys_i, .rst_i, .host_i,
  .selects_o, .rom_ack_normal_o, .rom_ack_delayed_o, .sram_transfer_ack_o);

// *** testbench/ack_line_model.sv ***
`timescale 1ns/10ps
module ack_line_model (
  // acknowledge drivers
  input  wire glue_pkg::tri_ack_t rom_n_i,
  input  wire glue_pkg::tri_ack_t rom_d_i,
  input  wire glue_pkg::tri_ack_t ram_i,
  // line seen by the host
  output logic                    ack_line_n_o
);
  import glue_pkg::*;
  // shared line with pull-up, so a released driver reads high
  always_comb begin
    ack_line_n_o = !((rom_n_i.oe && !rom_n_i.level) || (rom_d_i.oe && !rom_d_i.level)
                     || (ram_i.oe && !ram_i.level));
  end
endmodule : ack_line_model

// *** testbench/test_host_address_decoder_ack_gen.sv ***
`timescale 1ns/10ps
module test_host_address_decoder_ack_gen;
  import glue_pkg::*;
  typedef struct packed {logic [17:0] a; logic [4:0] c; selects_t s;} row_t;
  logic        clk_sys_i, rst_i, own_a, own_b, ack_n;
  host_cycle_t host;
  selects_t    sel;
  tri_ack_t    ackn, ackd, ackr;
  int          mismatches, checks_done, n;
  // address, {strobe, data strobe, read, owner a, owner b}, selects; A17 only in fetches
  row_t rows [11] = '{'{18'h00000, 5'h1f, 8'hff}, '{18'h04000, 5'h07, 8'h7f},
    '{18'h18000, 5'h07, 8'hdf}, '{18'h1c001, 5'h07, 8'hef}, '{18'h10000, 5'h07, 8'hbe},
    '{18'h14000, 5'h03, 8'hbd}, '{18'h10000, 5'h0e, 8'hbf}, '{18'h00000, 5'h0d, 8'h3f},
    '{18'h10000, 5'h04, 8'hff}, '{18'h3fff4, 5'h07, 8'he7}, '{18'h3fff0, 5'h07, 8'heb}};
  host_address_decoder_ack_gen u_host_address_decoder_ack_gen (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .host_i(host), .page_owner_a_i(own_a), .page_owner_b_i(own_b),
    .selects_o(sel), .rom_ack_normal_o(ackn), .rom_ack_delayed_o(ackd),
    .sram_transfer_ack_o(ackr));
  ack_line_model u_ack_line_model (.rom_n_i(ackn), .rom_d_i(ackd), .ram_i(ackr),
    .ack_line_n_o(ack_n));
  task automatic check(input string name, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // watchdog, the whole run needs about 100 cycles
  initial begin
    repeat (400) @(posedge clk_sys_i);
    mismatches++;
    end_of_test();
  end
  initial begin
    rst_i = 1'b1;
    {host, own_a, own_b} = {18'h00000, 5'h1f};
    repeat (10) @(posedge clk_sys_i);
    check("reset", {sel, ackn.oe, ackd.oe, ackr.oe}, 16'h07f8);
    rst_i <= 1'b0;
    // owners pass a filter, so each row settles for six edges
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_sys_i);
      {host, own_a, own_b} <= {rows[i].a, rows[i].c};
      repeat (6) @(posedge clk_sys_i);
      #1;
      check("selects", sel, rows[i].s);
      check("ack line", ack_n, rows[i].s.rom_select_n & rows[i].s.sram_select_n);
    end
    // fresh rom cycle straight after the last row's vector fetch: walk the wait chain edge by edge
    @(posedge clk_sys_i);
    host <= {18'h00000, 3'b011};
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (ackn.oe !== 1'b1 && n < 8);
    for (int k = 0; k < 4; k++) begin
      check("rom ack levels", {ackn.level, ackd.level}, 8'b11110100 >> (6 - 2 * k) & 3);
      @(posedge clk_sys_i);
      #1;
    end
    @(posedge clk_sys_i);
    host <= {18'h00000, 3'b111};
    repeat (2) @(posedge clk_sys_i);
    #1;
    check("ack released", {ackn.oe, ackd.oe, ack_n}, 3'b001);
    end_of_test();
  end
endmodule : test_host_address_decoder_ack_gen
